// ---- hdl/alarm_manager.sv ----
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module alarm_manager
    import alarm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Panel and remote command pins: start, stop, reset
    input wire logic [2:0] cmd_pin,
    // Failure conditions from the detectors, bit i is alarm code i+1
    input wire logic [N_ALARM-1:0] fault_cond,
    // Outputs
    output logic alarm_relay_output,
    output panel_t panel,
    output motor_t motor,
    output logic param_restore,
    output logic irq
);
    localparam int F2_IDX = 1;
    localparam int F3_IDX = 2;
    localparam int F4_IDX = 3;
    localparam int F15_IDX = 14;
    localparam int F17_IDX = 16;
    localparam int F18_IDX = 17;
    localparam int ACT_BITS = 3;

    logic wr_en;
    logic [AW-1:0] wr_addr, rd_addr;
    logic [DW-1:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic [2:0] pin_lvl, pin_prev;
    cmd_t cmd;
    action_t act [N_ALARM];
    action_t next_act [N_ALARM];
    logic reject;
    avec_t cond_q, next_cond_q, active, next_active, raise;
    avec_t notoff_vec, warn_vec, stop_vec, coast_vec, brake_vec, spin_vec, pure_stop_vec;
    logic [4:0] last_code, next_last_code, raise_code;
    run_state_t state, next_state;
    logic blocked;
    panel_t next_panel;
    motor_t next_motor;
    logic [N_IRQ-1:0] istat, next_istat, imask, next_imask, irq_event;

    axil_regport u_port (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    pin_sync #(.WIDTH(3)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(cmd_pin),
        .level(pin_lvl)
    );

    // Panel, remote and serial commands all merge here; a held pin acts once
    always_comb begin
        logic ctrl_wr;
        ctrl_wr = wr_en && wr_addr == OFS_CTRL && wr_strb[0];
        cmd.start = (ctrl_wr && wr_data[CB_START]) || (pin_lvl[CB_START] && !pin_prev[CB_START]);
        cmd.stop = (ctrl_wr && wr_data[CB_STOP]) || (pin_lvl[CB_STOP] && !pin_prev[CB_STOP]);
        cmd.reset = (ctrl_wr && wr_data[CB_RESET]) || (pin_lvl[CB_RESET] && !pin_prev[CB_RESET]);
        cmd.restore = ctrl_wr && wr_data[CB_RESTORE];
    end

    for (genvar g = 0; g < N_ALARM; g++) begin : g_vec
        assign notoff_vec[g] = act[g] != ACT_OFF;
        assign warn_vec[g] = act[g] == ACT_WARN;
        assign stop_vec[g] = act[g] >= ACT_COAST;
        assign coast_vec[g] = act[g] == ACT_COAST;
        assign brake_vec[g] = act[g] == ACT_BRAKE;
        assign spin_vec[g] = act[g] == ACT_SPIN;
        assign pure_stop_vec[g] = act[g] == ACT_STOP;
    end

    // Action table
    always_comb begin
        int base;
        int idx;
        logic [NIB-1:0] nib;
        base = 0;
        idx = 0;
        nib = '0;
        next_act = act;
        reject = 1'b0;
        if (cmd.restore) begin
            for (int i = 0; i < N_ALARM; i++) next_act[i] = ACT_DEFAULT;
        end else if (wr_en && wr_addr inside {OFS_ACT0, OFS_ACT1, OFS_ACT2}) begin
            base = (wr_addr == OFS_ACT1) ? PER_WORD : (wr_addr == OFS_ACT2) ? 2 * PER_WORD : 0;
            for (int k = 0; k < PER_WORD; k++) begin
                idx = base + k;
                nib = wr_data[k*NIB +: NIB];
                if (idx < N_ALARM && wr_strb[k/2]) begin
                    // Illegal choices keep the old action so protection never weakens
                    if (!nib[NIB-1] && permit(idx, nib[ACT_BITS-1:0])) begin
                        next_act[idx] = action_t'(nib[ACT_BITS-1:0]);
                    end else begin
                        reject = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_ALARM; i++) act[i] <= ACT_DEFAULT;
        end else begin
            act <= next_act;
        end
    end

    // Alarm set and clear; a new raise always wins over any clear
    always_comb begin
        raise = fault_cond & ~cond_q & notoff_vec;
        if (cmd.start) raise = raise | (fault_cond & notoff_vec);
        next_cond_q = fault_cond;
        if (cmd.restore) next_cond_q = fault_cond & ~MEM_MASK;
        next_active = active & ~(warn_vec & ~fault_cond);
        if (cmd.reset) next_active = next_active & MEM_MASK;
        if (cmd.start) next_active = next_active & ~AUTO_MASK;
        if (cmd.restore) next_active = next_active & ~MEM_MASK;
        next_active = next_active | raise;
        raise_code = top_code(raise);
        next_last_code = (raise != '0) ? raise_code : last_code;
        next_panel.flash = next_active != '0;
        if (next_active == '0) begin
            next_panel.code = 5'h00;
        end else if (next_last_code != 5'h00 && next_active[next_last_code - 5'h01]) begin
            next_panel.code = next_last_code;
        end else begin
            next_panel.code = top_code(next_active);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cond_q <= '0;
            active <= '0;
            last_code <= 5'h00;
            panel <= '0;
            alarm_relay_output <= 1'b0;
        end else begin
            cond_q <= next_cond_q;
            active <= next_active;
            last_code <= next_last_code;
            panel <= next_panel;
            alarm_relay_output <= next_panel.flash;
        end
    end

    // Motor sequencing; the most drastic action among live alarms governs
    always_comb begin
        blocked = (next_active & stop_vec) != '0;
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd.start && !blocked) next_state = ST_RUN;
                else if (blocked) next_state = ST_TRIP;
            end
            ST_RUN: begin
                if (blocked) next_state = ST_TRIP;
                else if (cmd.stop) next_state = ST_IDLE;
            end
            ST_TRIP: begin
                if (cmd.start && !blocked) next_state = ST_RUN;
                else if (!blocked) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        next_motor.run = next_state == ST_RUN;
        next_motor.coast = (next_active & coast_vec) != '0;
        next_motor.spin = !next_motor.coast && (next_active & spin_vec) != '0;
        next_motor.brake = !next_motor.coast && !next_motor.spin && (next_active & brake_vec) != '0;
        next_motor.stop = !next_motor.coast && !next_motor.spin && !next_motor.brake
                          && (next_active & pure_stop_vec) != '0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            motor <= '0;
            pin_prev <= '0;
            param_restore <= 1'b0;
        end else begin
            state <= next_state;
            motor <= next_motor;
            pin_prev <= pin_lvl;
            param_restore <= cmd.restore;
        end
    end

    // Interrupt status, write one to clear
    always_comb begin
        irq_event = '0;
        irq_event[IB_RAISE] = raise != '0;
        irq_event[IB_REJECT] = reject;
        irq_event[IB_TRIP] = state != ST_TRIP && next_state == ST_TRIP;
        next_istat = istat;
        next_imask = imask;
        if (wr_en && wr_addr == OFS_ISTAT && wr_strb[0]) next_istat = istat & ~wr_data[N_IRQ-1:0];
        if (wr_en && wr_addr == OFS_IMASK && wr_strb[0]) next_imask = wr_data[N_IRQ-1:0];
        next_istat = next_istat | irq_event;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            istat <= '0;
            imask <= '0;
            irq <= 1'b0;
        end else begin
            istat <= next_istat;
            imask <= next_imask;
            irq <= (next_istat & next_imask) != '0;
        end
    end

    // Register read view
    always_comb begin
        rd_data = '0;
        case (rd_addr)
            OFS_ACTIVE: rd_data = DW'(active);
            OFS_DISP: rd_data = DW'({alarm_relay_output, motor, panel});
            OFS_ISTAT: rd_data = DW'(istat);
            OFS_IMASK: rd_data = DW'(imask);
            OFS_COND: rd_data = DW'(fault_cond);
            OFS_ACT0, OFS_ACT1, OFS_ACT2: begin
                for (int k = 0; k < PER_WORD; k++) begin
                    if (((rd_addr == OFS_ACT1) ? PER_WORD : (rd_addr == OFS_ACT2) ? 2 * PER_WORD : 0)
                        + k < N_ALARM) begin
                        rd_data[k*NIB +: NIB] = {1'b0, act[((rd_addr == OFS_ACT1) ? PER_WORD :
                            (rd_addr == OFS_ACT2) ? 2 * PER_WORD : 0) + k]};
                    end
                end
            end
            default: rd_data = '0;
        endcase
    end

    // Checks
    avec_t man_keep;
    logic f4_pick, f3_bad;
    logic [ACT_BITS-1:0] f4_val;
    assign man_keep = active & MAN_MASK & ~warn_vec;
    assign f4_val = wr_data[F4_IDX*NIB +: ACT_BITS];
    assign f4_pick = wr_en && wr_addr == OFS_ACT0 && wr_strb[F4_IDX/2]
                     && !wr_data[F4_IDX*NIB + ACT_BITS] && f4_val <= ACT_BRAKE;
    assign f3_bad = wr_en && wr_addr == OFS_ACT0 && wr_strb[F3_IDX/2]
                    && wr_data[F3_IDX*NIB +: ACT_BITS] != ACT_COAST;

    a_auto_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd.start && (fault_cond & AUTO_MASK) == '0 |=> (active & AUTO_MASK) == '0)
        else $error("auto alarm survived start");
    a_manual_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cmd.reset |=> (active & $past(man_keep)) == $past(man_keep))
        else $error("latched alarm dropped without reset");
    a_forced_coast: assert property (@(posedge clk_sys) disable iff (!rst_n)
        act[F3_IDX] == ACT_COAST && act[F18_IDX] == ACT_COAST)
        else $error("fixed coast action changed");
    a_f4_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        f4_pick |=> act[F4_IDX] == $past(f4_val))
        else $error("F4 action not stored");
    a_comm_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(fault_cond[F15_IDX]) && act[F15_IDX] != ACT_OFF |=> active[F15_IDX])
        else $error("comm loss alarm not raised");
    a_mem_coast: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (active & MEM_MASK) != '0 |-> motor.coast && state != ST_RUN)
        else $error("memory alarm without coast");
    a_mem_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        active[F18_IDX] && !cmd.restore |=> active[F18_IDX])
        else $error("memory alarm cleared by command");
    a_restore_dflt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd.restore |=> act[0] == ACT_DEFAULT && act[F17_IDX] == ACT_DEFAULT ##0 param_restore)
        else $error("factory restore incomplete");
    a_warn_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        act[F2_IDX] == ACT_WARN && !fault_cond[F2_IDX] |=> !active[F2_IDX])
        else $error("warning alarm stuck");
    a_latest_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        raise != '0 |=> panel.code == $past(raise_code) && alarm_relay_output)
        else $error("display not showing latest alarm");
    a_start_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd.start && (fault_cond & stop_vec) != '0 |=> state == ST_TRIP && alarm_relay_output)
        else $error("start accepted during failure");
    a_reset_nostart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state != ST_RUN && !cmd.start |=> state != ST_RUN)
        else $error("motor started without start");
    a_reject_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        f3_bad |=> istat[IB_REJECT] && act[F3_IDX] == ACT_COAST)
        else $error("illegal action not rejected");
endmodule : alarm_manager

// ---- hdl/alarm_pkg.sv ----
package alarm_pkg;
    localparam int N_ALARM = 19;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NIB = 4;
    localparam int PER_WORD = 8;
    localparam int N_IRQ = 3;
    typedef logic [N_ALARM-1:0] avec_t;
    typedef enum logic [2:0] {
        ACT_OFF = 3'h0,
        ACT_WARN = 3'h1,
        ACT_COAST = 3'h2,
        ACT_STOP = 3'h3,
        ACT_BRAKE = 3'h4,
        ACT_SPIN = 3'h5
    } action_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_TRIP = 2'h3
    } run_state_t;
    localparam action_t ACT_DEFAULT = ACT_COAST;
    // Bit i stands for alarm code i+1
    localparam avec_t AUTO_MASK = 19'h04789;
    localparam avec_t MAN_MASK = 19'h1B876;
    localparam avec_t MEM_MASK = 19'h60000;
    localparam avec_t FULL_MASK = 19'h143EA;
    localparam avec_t COAST_MASK = 19'h63804;
    localparam avec_t OWC_MASK = 19'h08410;
    localparam avec_t WC_MASK = 19'h00001;
    localparam avec_t SPIN_MASK = 19'h10000;
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_ACTIVE = 8'h04;
    localparam logic [AW-1:0] OFS_DISP = 8'h08;
    localparam logic [AW-1:0] OFS_ISTAT = 8'h0C;
    localparam logic [AW-1:0] OFS_IMASK = 8'h10;
    localparam logic [AW-1:0] OFS_ACT0 = 8'h14;
    localparam logic [AW-1:0] OFS_ACT1 = 8'h18;
    localparam logic [AW-1:0] OFS_ACT2 = 8'h1C;
    localparam logic [AW-1:0] OFS_COND = 8'h20;
    localparam int CB_START = 0;
    localparam int CB_STOP = 1;
    localparam int CB_RESET = 2;
    localparam int CB_RESTORE = 3;
    localparam int IB_RAISE = 0;
    localparam int IB_REJECT = 1;
    localparam int IB_TRIP = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic start;
        logic stop;
        logic reset;
        logic restore;
    } cmd_t;
    typedef struct packed {
        logic flash;
        logic [4:0] code;
    } panel_t;
    typedef struct packed {
        logic run;
        logic coast;
        logic stop;
        logic brake;
        logic spin;
    } motor_t;

    function automatic logic permit(input int idx, input logic [2:0] a);
        logic ok;
        ok = 1'b0;
        if (idx < N_ALARM) begin
            if (FULL_MASK[idx]) ok = (a <= ACT_BRAKE) || (SPIN_MASK[idx] && a == ACT_SPIN);
            if (OWC_MASK[idx]) ok = (a <= ACT_COAST);
            if (WC_MASK[idx]) ok = (a == ACT_WARN) || (a == ACT_COAST);
            if (COAST_MASK[idx]) ok = (a == ACT_COAST);
        end
        return ok;
    endfunction : permit

    // Highest set index as an alarm code, zero when none
    function automatic logic [4:0] top_code(input avec_t v);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < N_ALARM; i++) begin
            if (v[i]) c = 5'(i + 1);
        end
        return c;
    endfunction : top_code

    function automatic logic addr_ok(input logic [AW-1:0] a);
        return a inside {OFS_CTRL, OFS_ACTIVE, OFS_DISP, OFS_ISTAT, OFS_IMASK,
                         OFS_ACT0, OFS_ACT1, OFS_ACT2, OFS_COND};
    endfunction : addr_ok
endpackage : alarm_pkg

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] pin,
    // Filtered level
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1, s2, s3, next_level;

    // A change counts only once the last two stages agree
    always_comb begin
        next_level = (s2 & ~(s2 ^ s3)) | (level & (s2 ^ s3));
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule : pin_sync

// ---- hdl/axil_regport.sv ----
`timescale 1ns/100ps
module axil_regport
    import alarm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [DW-1:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [AW-1:0] rd_addr,
    input wire logic [DW-1:0] rd_data
);
    logic aw_full, next_aw_full, w_full, next_w_full, next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [AW-1:0] next_wr_addr;
    logic [DW-1:0] next_wr_data, next_rdata;
    logic [3:0] next_wr_strb;

    assign awready = !aw_full;
    assign wready = !w_full;
    assign arready = !rvalid;
    assign rd_addr = araddr;
    // Response slot must be free so a write never overruns an unread answer
    assign wr_en = aw_full && w_full && !bvalid;

    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_wr_data = wdata;
            next_wr_strb = wstrb;
        end
        if (bvalid && bready) next_bvalid = 1'b0;
        if (wr_en) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && rready) next_rvalid = 1'b0;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata = addr_ok(araddr) ? rd_data : '0;
            next_rresp = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule : axil_regport

// ---- tb/cmd_panel.sv ----
`timescale 1ns/100ps
module cmd_panel (
    // Clock
    input wire logic clk_sys,
    // One-cycle request: start, stop, reset
    input wire logic [2:0] req,
    // Command pins
    output logic [2:0] cmd_pin
);
    int hold = 0;
    initial cmd_pin = 3'h0;
    // Held 7 cycles so the pin filter surely sees it
    always @(posedge clk_sys) begin
        if (req != 3'h0) begin
            cmd_pin <= req;
            hold <= 6;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            cmd_pin <= 3'h0;
        end
    end
endmodule : cmd_panel

// ---- tb/alarm_manager_bench.sv ----
`timescale 1ns/100ps
module alarm_manager_bench;
    import alarm_pkg::*;
    logic clk_sys = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic alarm_relay_output, param_restore, irq;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [18:0] fault_cond = 0;
    logic [2:0] req = 0, cmd_pin;
    panel_t panel;
    motor_t motor;
    int n_mismatch = 0, check_count = 0, n_restore = 0;
    always #5 clk_sys = ~clk_sys;
    // Counts restore pulse cycles so a stuck or missing pulse shows up
    always @(posedge clk_sys) if (param_restore) n_restore <= n_restore + 1;
    cmd_panel pnl (.clk_sys, .req, .cmd_pin);
    alarm_manager dut (.clk_sys, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .cmd_pin, .fault_cond, .alarm_relay_output, .panel,
        .motor, .param_restore, .irq);
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Bounded waits: a hang ends the run as a mismatch
    task tick(inout int n);
        n++;
        if (n > 100) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask : tick
    task w(input int k);
        repeat (k) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : w
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw;
        n = 0;
        @(posedge clk_sys);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        ta = 0; tw = 0;
        while (!(ta && tw)) begin
            @(negedge clk_sys);
            tick(n);
            @(posedge clk_sys);
            if (awready) begin awvalid <= 0; ta = 1; end
            if (wready) begin wvalid <= 0; tw = 1; end
        end
        do begin @(negedge clk_sys); tick(n); end while (!bvalid);
        chk(32'(bresp), 32'(RESP_OKAY));
        @(posedge clk_sys);
        bready <= 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin @(negedge clk_sys); tick(n); end while (!arready);
        @(posedge clk_sys);
        arvalid <= 0;
        do begin @(negedge clk_sys); tick(n); end while (!rvalid);
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        @(posedge clk_sys);
        rready <= 0;
    endtask : rd
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1;
        w(4);
        rd(OFS_ACT0, 32'h22222222, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_IMASK, 32'h3);
        // F1 and F3 off are illegal, F2 warning, F4 alarm brake
        wr(OFS_ACT0, 32'h22224010);
        rd(OFS_ACT0, 32'h22224212, RESP_OKAY);
        // No alarm has been raised yet, only the reject flag stands
        rd(OFS_ISTAT, 32'h2, RESP_OKAY);
        chk(irq, 1);
        wr(OFS_ISTAT, 32'h3);
        chk(irq, 0);
        fault_cond[1] <= 1;
        w(3);
        chk({alarm_relay_output, panel}, {2'b11, 5'd2});
        @(posedge clk_sys) fault_cond[1] <= 0;
        w(3);
        chk({alarm_relay_output, panel.flash}, 2'b00);
        @(posedge clk_sys) fault_cond[3] <= 1;
        w(3);
        chk(motor.brake, 1);
        @(posedge clk_sys) fault_cond[5] <= 1;
        w(3);
        chk(panel.code, 6);
        @(posedge clk_sys) fault_cond <= 0;
        wr(OFS_CTRL, 32'h1);
        rd(OFS_ACTIVE, 32'h20, RESP_OKAY);
        @(posedge clk_sys) req <= 3'h4;
        @(posedge clk_sys) req <= 3'h0;
        w(10);
        rd(OFS_ACTIVE, 32'h0, RESP_OKAY);
        chk({alarm_relay_output, motor.run}, 2'b00);
        fault_cond[2] <= 1;
        w(3);
        wr(OFS_CTRL, 32'h4);
        rd(OFS_ACTIVE, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_ACTIVE, 32'h4, RESP_OKAY);
        chk({motor.run, motor.coast}, 2'b01);
        fault_cond[2] <= 0;
        fault_cond[17] <= 1;
        w(3);
        chk({motor.coast, panel.code}, {1'b1, 5'd18});
        @(posedge clk_sys) fault_cond[17] <= 0;
        wr(OFS_CTRL, 32'h4);
        rd(OFS_ACTIVE, 32'h20000, RESP_OKAY);
        wr(OFS_CTRL, 32'h8);
        w(3);
        rd(OFS_ACTIVE, 32'h0, RESP_OKAY);
        rd(OFS_ACT0, 32'h22222222, RESP_OKAY);
        chk(n_restore, 1);
        // Spin brake is legal for F17 only; off is refused for F18 and F19
        wr(OFS_ACT2, 32'h5);
        rd(OFS_ACT2, 32'h225, RESP_OKAY);
        wr(OFS_CTRL, 32'h1);
        chk(motor.run, 1);
        wr(OFS_CTRL, 32'h2);
        chk(motor.run, 0);
        fault_cond[16] <= 1;
        w(3);
        chk({motor.run, motor.spin}, 2'b01);
        rd(OFS_DISP, 32'h871, RESP_OKAY);
        fault_cond[14] <= 1;
        w(3);
        chk(panel.code, 15);
        report_and_stop;
    end
endmodule : alarm_manager_bench
